//--- bench/spm_assertions.sv
`timescale 1ns/1ns
//==================================================
// port checks
module spm_assertions (
	input wire        i_clk,
	input wire        i_rst,
	input wire [7:0]  i_addr,
	input wire [31:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [31:0] o_rdata,
	input wire        i_rs485,
	input wire        o_txd,
	input wire        o_rts,
	input wire        o_dtr
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	reset_out_a: assert property (disable iff (1'b0) i_rst |=> o_txd && !o_rts && !o_dtr && o_rdata == 32'h0)
		else $error("outputs not at reset level");
	rs485_flow_a: assert property (i_rs485 [*2] |-> !o_rts && !o_dtr)
		else $error("flow pins active on rs485");
	ctrl_back_a: assert property (i_wr && i_addr == 8'h00 ##2 i_rd && i_addr == 8'h00 |=>
		o_rdata[9:0] == $past(i_wdata[9:0], 3)) else $error("control readback wrong");
	xchr_back_a: assert property (i_wr && i_addr == 8'h08 ##2 i_rd && i_addr == 8'h08 |=>
		o_rdata[15:0] == $past(i_wdata[15:0], 3)) else $error("flow char readback wrong");
	start_len_a: assert property ($fell(o_txd) |-> !o_txd [*4])
		else $error("low bit too short");
	dtr_hw_a: assert property (i_wr && i_addr == 8'h00 && (i_wdata[9] ^ i_wdata[8]) && !i_rs485 |-> ##[1:3] o_dtr)
		else $error("dtr not raised");
	rts_on_a: assert property (i_wr && i_addr == 8'h00 && i_wdata[9:8] == 2'h2 && !i_rs485 |-> ##[1:3] o_rts)
		else $error("rts not held on");
	rts_dtr_a: assert property ($rose(o_rts) |-> o_dtr)
		else $error("rts without dtr");
endmodule // spm_assertions

//--- bench/spm_peer.sv
`timescale 1ns/1ns
//==================================================
// serial peer
module spm_peer (
	input  wire        i_clk,
	input  wire [15:0] i_div,
	input  wire        i_txd,
	output reg         o_rxd,
	output reg         o_got,
	output reg         o_par,
	output reg  [7:0]  o_byte
);
	integer k;
	// may be called while a character is arriving
	task send(input [7:0] b);
		reg [9:0] fr;
		integer j;
		begin
			fr = {1'b1, b, 1'b0};
			for (j = 0; j < 10; j = j + 1) begin
				o_rxd <= fr[j];
				repeat (i_div) @(posedge i_clk);
			end
		end
	endtask
	initial begin
		o_rxd = 1'b1;
		o_got = 1'b0;
		o_par = 1'b0;
		o_byte = 8'h00;
		forever begin
			@(posedge i_clk);
			o_got <= 1'b0;
			if (i_txd === 1'b0) begin
				repeat (i_div / 2) @(posedge i_clk);
				for (k = 0; k < 8; k = k + 1) begin
					repeat (i_div) @(posedge i_clk);
					o_byte[k] <= i_txd;
				end
				repeat (i_div) @(posedge i_clk);
				// parity bit, or first stop bit
				o_par <= i_txd;
				o_got <= 1'b1;
				while (i_txd !== 1'b1) begin
					@(posedge i_clk);
					o_got <= 1'b0;
				end
			end
		end
	end
endmodule // spm_peer

//--- bench/spm_top_tb.sv
`timescale 1ns/1ns
//==================================================
// bench
module spm_top_tb;
	localparam int CLK_HZ = 500000;
	reg		i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_rs485 = 1'b0, i_cts = 1'b0, i_dsr = 1'b0;
	reg  [7:0]	i_addr = 8'h00;
	reg  [31:0]	i_wdata = 32'h0;
	reg  [15:0]	div = 16'd52;
	reg  [2:0]	pm = 3'h0;
	reg		rd_d = 1'b0;
	wire		i_rxd, o_txd, o_rts, o_dtr, got, pbit;
	wire [31:0]	o_rdata;
	wire [7:0]	gbyte;
	int		err_count = 0, compares = 0, cyc = 0, last = 0, gap = 0, t, s, k;
	int		rate [11] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 28400, 57600, 76800, 115200};
	logic [31:0]	exp_v [$], exp_m [$];
	logic [8:0]	exp_b [$];
	logic [7:0]	rx [17];
	spm_top #(.P_CLK_HZ(CLK_HZ), .P_MS_CYCLES(50)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rs485(i_rs485), .i_rxd(i_rxd),
		.i_cts(i_cts), .i_dsr(i_dsr), .o_txd(o_txd), .o_rts(o_rts), .o_dtr(o_dtr));
	spm_peer peer (.i_clk(i_clk), .i_div(div), .i_txd(o_txd), .o_rxd(i_rxd), .o_got(got), .o_par(pbit),
		.o_byte(gbyte));
	always #5 i_clk = ~i_clk;
	task check(input string n, input [31:0] e, input [31:0] v);
		compares++;
		if (v !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, v);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		rd_d <= i_rd;
		if (rd_d)
			check("rdata", exp_v.pop_front(), o_rdata & exp_m.pop_front());
		if (got) begin
			check("txbyte", exp_b.pop_front(), {pbit, gbyte});
			gap <= cyc - last;
			last <= cyc;
		end
		if (cyc == 80000) begin
			err_count++;
			print_verdict;
		end
	end
	task wr(input [7:0] a, input [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_v.push_back(e & m);
		exp_m.push_back(m);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task txb(input [7:0] b);
		exp_b.push_back({pm == 3'h1 ? ^b : pm == 3'h2 ? ~^b : pm != 3'h4, b});
		wr(8'h0c, {24'h0, b});
	endtask
	task drain;
		while (exp_b.size() != 0)
			@(posedge i_clk);
		repeat (3 * div) @(posedge i_clk);
	endtask
	initial begin
		void'($urandom(20));
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'h00, 32'h005, 32'h3ff);
		rd(8'h04, 32'h3e8, 32'hffff);
		rd(8'h08, 32'h1311, 32'hffff);
		rd(8'h14, 32'h001, 32'h1ff);
		rd(8'hfc, 32'h0, 32'hffffffff);
		$display("t1 done");
		for (t = 0; t < 11; t++) begin
			div = 16'(CLK_HZ / rate[t]);
			wr(8'h00, t);
			rd(8'h00, t, 32'h3ff);
			txb(8'($urandom));
			drain;
		end
		$display("t2 done");
		div = 16'd26;
		for (t = 0; t < 10; t++) begin
			pm = 3'(t / 2);
			s = t % 2;
			wr(8'h00, {24'h0, s[0], pm, 4'h6});
			txb(8'($urandom));
			txb(8'($urandom));
			drain;
			k = (10 + (pm != 0) + s) * div;
			check("gap", 1, gap >= k && gap <= k + 3);
		end
		pm = 3'h0;
		$display("t3 done");
		i_rs485 <= 1'b1;
		wr(8'h00, 32'h106);
		txb(8'($urandom));
		drain;
		i_rs485 <= 1'b0;
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h106);
		txb(8'($urandom));
		repeat (20) @(posedge i_clk);
		#1 check("rts", 0, o_rts);
		@(posedge i_clk);
		i_dsr <= 1'b1;
		repeat (20) @(posedge i_clk);
		#1 check("rts", 1, o_rts);
		check("dtr", 1, o_dtr);
		rd(8'h14, 32'h0, 32'h1);
		i_dsr <= 1'b0;
		i_cts <= 1'b1;
		drain;
		#1 check("rts", 0, o_rts);
		@(posedge i_clk);
		i_dsr <= 1'b1;
		txb(8'($urandom));
		txb(8'($urandom));
		while (exp_b.size() == 2)
			@(posedge i_clk);
		i_cts <= 1'b0;
		repeat (60) @(posedge i_clk);
		check("held", 1, exp_b.size());
		i_cts <= 1'b1;
		drain;
		i_cts <= 1'b0;
		wr(8'h0c, 32'h33);
		repeat (250) @(posedge i_clk);
		rd(8'h14, 32'h21, 32'h21);
		wr(8'h14, 32'h20);
		rd(8'h14, 32'h0, 32'h20);
		$display("t4 done");
		div = 16'd4;
		wr(8'h00, 32'h20a);
		txb(8'($urandom));
		drain;
		for (k = 0; k < 17; k++) begin
			rx[k] = 8'($urandom);
			peer.send(rx[k]);
		end
		repeat (4) @(posedge i_clk);
		#1 check("rts", 1, o_rts);
		rd(8'h14, 32'h45, 32'h45);
		for (k = 0; k < 16; k++)
			rd(8'h10, {24'h0, rx[k]}, 32'hff);
		rd(8'h14, 32'h0, 32'h4);
		$display("t5 done");
		wr(8'h04, 32'h4);
		wr(8'h08, 32'h5aa5);
		rd(8'h08, 32'h5aa5, 32'hffff);
		wr(8'h00, 32'h30a);
		peer.send(8'h5a);
		txb(8'($urandom));
		repeat (60) @(posedge i_clk);
		rd(8'h14, 32'h10, 32'h11);
		peer.send(8'ha5);
		drain;
		rd(8'h14, 32'h0, 32'h14);
		peer.send(8'h5a);
		wr(8'h0c, 32'h77);
		repeat (350) @(posedge i_clk);
		rd(8'h14, 32'h21, 32'h21);
		$display("t6 done");
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'h00, 32'h005, 32'h3ff);
		rd(8'h08, 32'h1311, 32'hffff);
		repeat (3) @(posedge i_clk);
		$display("t7 done");
		print_verdict;
	end
endmodule // spm_top_tb
bind spm_top spm_assertions chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_rs485(i_rs485), .o_txd(o_txd), .o_rts(o_rts), .o_dtr(o_dtr));

//--- verilog/spm_defs.vh
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH
// register offsets (byte addresses)
`define SPM_A_CTRL    8'h00
`define SPM_A_WAIT    8'h04
`define SPM_A_XCHR    8'h08
`define SPM_A_TXD     8'h0c
`define SPM_A_RXD     8'h10
`define SPM_A_STAT    8'h14
// control fields
`define SPM_F_BAUD    3:0
`define SPM_F_PAR     6:4
`define SPM_B_STOP2   7
`define SPM_F_FLOW    9:8
`define SPM_CTRL_RST  10'h005
// wait time and flow characters
`define SPM_WAIT_RST  16'h03e8
`define SPM_XON_RST   8'h11
`define SPM_XOFF_RST  8'h13
// parity modes
`define SPM_PAR_NONE  3'h0
`define SPM_PAR_EVEN  3'h1
`define SPM_PAR_ODD   3'h2
`define SPM_PAR_MARK  3'h3
`define SPM_PAR_SPACE 3'h4
// flow control modes
`define SPM_FL_NONE   2'h0
`define SPM_FL_HWSW   2'h1
`define SPM_FL_HWON   2'h2
`define SPM_FL_SOFT   2'h3
// status bits
`define SPM_S_TXEMP   0
`define SPM_S_TXFULL  1
`define SPM_S_RXAV    2
`define SPM_S_BUSY    3
`define SPM_S_XOFF    4
`define SPM_S_ABORT   5
`define SPM_S_OVF     6
`define SPM_S_PERR    7
`define SPM_S_FERR    8
// timing and fifo size
`define SPM_CLK_HZ    100000000
`define SPM_CLK_NS    10
`define SPM_MS_NS     1000000
`define SPM_MS_CYC    (`SPM_MS_NS / `SPM_CLK_NS)
`define SPM_FIFO_W    8
`define SPM_FIFO_D    16
`define SPM_FIFO_AW   4
`endif

//--- verilog/spm_top.v
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "spm_defs.vh"
// Behaviour
// [RL1] baud rates 300 to 115200 selectable, 9600 after reset
// [RL2] parity none, even, odd, mark or space; none after reset
// [RL3] one or two stop bits; one after reset
// [RL4] wait time in milliseconds, 0 to 65535
// [RL5] wait time expiry aborts transmission and reports an error
// [RL6] flow control only on RS-232; RS-485 sends without flow control
// [RL7] hardware flow picks RTS always on or RTS switched
// [RL8] switched: raise RTS to send, send only while CTS active
// [RL9] switched: resume on CTS, abort with error after wait time
// [RL10] always on: RTS stays asserted continuously
// [RL11] remote sender must not overrun our receive buffer; nothing throttles the sender, and a full buffer drops the character (RL19)
// [RL12] DTR asserted in either hardware flow mode
// [RL13] hardware flow: DSR checked only at start of a send
// [RL14] software flow: stop on XOFF, resume on XON
// [RL15] no XON within wait time aborts with error
// [RL16] XON and XOFF characters configurable
// [RL17] software flow needs full duplex link
// [RL18] runtime settings override defaults and are lost at reset
// [RL19] character arriving with receive buffer full is dropped, sticky flag set

//==================================================
// fifo
module spm_fifo #(
	parameter W  = `SPM_FIFO_W,
	parameter D  = `SPM_FIFO_D,
	parameter AW = `SPM_FIFO_AW
) (
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire         i_flush,
	input  wire         i_wr_valid,
	output wire         o_wr_ready,
	input  wire [W-1:0] i_wr_data,
	output wire         o_rd_valid,
	input  wire         i_rd_ready,
	output wire [W-1:0] o_rd_data
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wp_reg;
	reg [AW-1:0] rp_reg;
	reg [AW:0]   cnt_reg;
	wire         push;
	wire         pop;

	assign o_wr_ready = (cnt_reg != D[AW:0]);
	assign o_rd_valid = (cnt_reg != {(AW+1){1'b0}});
	assign o_rd_data  = mem[rp_reg];
	assign push       = i_wr_valid & o_wr_ready;
	assign pop        = i_rd_ready & o_rd_valid;

	always @(posedge i_clk) begin
		if (push)
			mem[wp_reg] <= i_wr_data;
	end

	always @(posedge i_clk) begin
		if (i_rst | i_flush) begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // spm_fifo

//==================================================
// serial port
module spm_top #(
	parameter P_CLK_HZ    = `SPM_CLK_HZ,
	parameter P_MS_CYCLES = `SPM_MS_CYC
) (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	input  wire        i_rs485,
	input  wire        i_rxd,
	input  wire        i_cts,
	input  wire        i_dsr,
	output reg         o_txd,
	output reg         o_rts,
	output reg         o_dtr
);
	localparam T_IDLE  = 3'h0;
	localparam T_GATE  = 3'h1;
	localparam T_START = 3'h2;
	localparam T_DATA  = 3'h3;
	localparam T_PAR   = 3'h4;
	localparam T_STOP  = 3'h5;
	localparam R_IDLE  = 3'h0;
	localparam R_START = 3'h1;
	localparam R_DATA  = 3'h2;
	localparam R_PAR   = 3'h3;
	localparam R_STOP  = 3'h4;

	reg [9:0]  ctrl_reg;
	reg [15:0] wait_reg;
	reg [7:0]  xon_reg;
	reg [7:0]  xoff_reg;
	reg        xhold_reg;
	reg        abort_reg;
	reg        ovf_reg;
	reg        perr_reg;
	reg        ferr_reg;
	reg [2:0]  ts_reg;
	reg [19:0] tcnt_reg;
	reg [2:0]  tbit_reg;
	reg [7:0]  tsh_reg;
	reg        tpar_reg;
	reg        tstp_reg;
	reg [31:0] mspre_reg;
	reg [15:0] ms_reg;
	reg [2:0]  rs_reg;
	reg [19:0] rcnt_reg;
	reg [2:0]  rbit_reg;
	reg [7:0]  rsh_reg;
	reg        rpush_reg;
	reg [7:0]  rbyte_reg;

	// bit period in clocks for a rate selection
	function [19:0] f_div;
		input [3:0] s;
		integer r;
		begin
			case (s)
			4'h0:    r = P_CLK_HZ / 300;
			4'h1:    r = P_CLK_HZ / 600;
			4'h2:    r = P_CLK_HZ / 1200;
			4'h3:    r = P_CLK_HZ / 2400;
			4'h4:    r = P_CLK_HZ / 4800;
			4'h6:    r = P_CLK_HZ / 19200;
			4'h7:    r = P_CLK_HZ / 28400;
			4'h8:    r = P_CLK_HZ / 57600;
			4'h9:    r = P_CLK_HZ / 76800;
			4'ha:    r = P_CLK_HZ / 115200;
			default: r = P_CLK_HZ / 9600;
			endcase
			f_div = r[19:0];
		end
	endfunction

	// parity bit to send or expect
	function f_par;
		input [2:0] m;
		input [7:0] d;
		begin
			case (m)
			`SPM_PAR_EVEN: f_par = ^d;
			`SPM_PAR_ODD:  f_par = ~^d;
			`SPM_PAR_MARK: f_par = 1'b1;
			default:       f_par = 1'b0;
			endcase
		end
	endfunction

	//==================================================
	// effective settings
	wire [19:0] div     = f_div(ctrl_reg[`SPM_F_BAUD]); // RL1
	wire [2:0]  pmode   = ctrl_reg[`SPM_F_PAR];
	wire        par_on  = (pmode != `SPM_PAR_NONE);
	wire [1:0]  flow    = i_rs485 ? `SPM_FL_NONE : ctrl_reg[`SPM_F_FLOW]; // RL6
	wire        hw      = (flow == `SPM_FL_HWSW) | (flow == `SPM_FL_HWON);
	wire        sw      = (flow == `SPM_FL_SOFT);
	wire        ttick   = (tcnt_reg == div - 20'h1);
	wire        rfull   = (rcnt_reg == div - 20'h1);
	wire        rhalf   = (rcnt_reg == {1'b0, div[19:1]});

	//==================================================
	// fifos
	wire        reg_wr_tx = i_wr & (i_addr == `SPM_A_TXD);
	wire        reg_rd_rx = i_rd & (i_addr == `SPM_A_RXD);
	wire        tx_ready;
	wire        tx_valid;
	wire [7:0]  tx_data;
	wire        rx_ready;
	wire        rx_valid;
	wire [7:0]  rx_data;
	wire        t_go;
	wire        t_abort;

	spm_fifo #(.W(`SPM_FIFO_W), .D(`SPM_FIFO_D), .AW(`SPM_FIFO_AW)) u_txf (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_flush    (t_abort),
		.i_wr_valid (reg_wr_tx),
		.o_wr_ready (tx_ready),
		.i_wr_data  (i_wdata[7:0]),
		.o_rd_valid (tx_valid),
		.i_rd_ready (t_go),
		.o_rd_data  (tx_data)
	);

	spm_fifo #(.W(`SPM_FIFO_W), .D(`SPM_FIFO_D), .AW(`SPM_FIFO_AW)) u_rxf (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_flush    (1'b0),
		.i_wr_valid (rpush_reg),
		.o_wr_ready (rx_ready),
		.i_wr_data  (rbyte_reg),
		.o_rd_valid (rx_valid),
		.i_rd_ready (reg_rd_rx),
		.o_rd_data  (rx_data)
	);

	//==================================================
	// transmit permission and wait timer
	wire t_ok    = (flow == `SPM_FL_HWSW) ? i_cts : (sw ? ~xhold_reg : 1'b1); // RL8 RL14
	wire t_block = (ts_reg == T_GATE) & tx_valid & ~t_ok;
	assign t_go    = (ts_reg == T_GATE) & tx_valid & t_ok;
	assign t_abort = t_block & (ms_reg >= wait_reg); // RL5 RL9 RL15

	always @(posedge i_clk) begin
		if (i_rst | ~t_block) begin
			mspre_reg <= 32'h0;
			ms_reg    <= 16'h0;
		end else if (mspre_reg == P_MS_CYCLES - 1) begin
			mspre_reg <= 32'h0;
			if (ms_reg != 16'hffff)
				ms_reg <= ms_reg + 16'h1; // RL4
		end else begin
			mspre_reg <= mspre_reg + 32'h1;
		end
	end

	//==================================================
	// transmitter
	always @(posedge i_clk) begin
		if (i_rst) begin
			ts_reg   <= T_IDLE;
			tcnt_reg <= 20'h0;
			tbit_reg <= 3'h0;
			tsh_reg  <= 8'h0;
			tpar_reg <= 1'b0;
			tstp_reg <= 1'b0;
			o_txd    <= 1'b1;
		end else begin
			tcnt_reg <= ttick ? 20'h0 : tcnt_reg + 20'h1;
			case (ts_reg)
			T_IDLE: begin
				if (tx_valid & (~hw | i_dsr)) // RL13
					ts_reg <= T_GATE;
			end
			T_GATE: begin
				if (!tx_valid | t_abort) begin
					ts_reg <= T_IDLE;
				end else if (t_ok) begin
					ts_reg   <= T_START;
					tsh_reg  <= tx_data;
					tpar_reg <= f_par(pmode, tx_data); // RL2
					tcnt_reg <= 20'h0;
					o_txd    <= 1'b0;
				end
			end
			T_START: begin
				if (ttick) begin
					ts_reg   <= T_DATA;
					tbit_reg <= 3'h0;
					o_txd    <= tsh_reg[0];
				end
			end
			T_DATA: begin
				if (ttick) begin
					tsh_reg  <= {1'b0, tsh_reg[7:1]};
					tbit_reg <= tbit_reg + 3'h1;
					if (tbit_reg == 3'h7) begin
						ts_reg   <= par_on ? T_PAR : T_STOP;
						o_txd    <= par_on ? tpar_reg : 1'b1;
						tstp_reg <= 1'b0;
					end else begin
						o_txd <= tsh_reg[1];
					end
				end
			end
			T_PAR: begin
				if (ttick) begin
					ts_reg <= T_STOP;
					o_txd  <= 1'b1;
				end
			end
			T_STOP: begin
				if (ttick) begin
					if (ctrl_reg[`SPM_B_STOP2] & ~tstp_reg) // RL3
						tstp_reg <= 1'b1;
					else
						ts_reg <= T_GATE;
				end
			end
			default: ts_reg <= T_IDLE;
			endcase
		end
	end

	//==================================================
	// modem control lines
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rts <= 1'b0;
			o_dtr <= 1'b0;
		end else begin
			o_dtr <= hw; // RL12
			if (flow == `SPM_FL_HWON)
				o_rts <= 1'b1; // RL10
			else if (flow == `SPM_FL_HWSW)
				o_rts <= (ts_reg != T_IDLE) & ~t_abort & ~((ts_reg == T_GATE) & ~tx_valid); // RL7 RL8
			else
				o_rts <= 1'b0;
		end
	end

	//==================================================
	// receiver
	always @(posedge i_clk) begin
		if (i_rst) begin
			rs_reg    <= R_IDLE;
			rcnt_reg  <= 20'h0;
			rbit_reg  <= 3'h0;
			rsh_reg   <= 8'h0;
			rpush_reg <= 1'b0;
			rbyte_reg <= 8'h0;
		end else begin
			rpush_reg <= 1'b0;
			rcnt_reg  <= rfull ? 20'h0 : rcnt_reg + 20'h1;
			case (rs_reg)
			R_IDLE: begin
				rcnt_reg <= 20'h0;
				if (!i_rxd)
					rs_reg <= R_START;
			end
			R_START: begin
				if (rhalf) begin
					rcnt_reg <= 20'h0;
					rbit_reg <= 3'h0;
					rs_reg   <= i_rxd ? R_IDLE : R_DATA;
				end
			end
			R_DATA: begin
				if (rfull) begin
					rsh_reg  <= {i_rxd, rsh_reg[7:1]};
					rbit_reg <= rbit_reg + 3'h1;
					if (rbit_reg == 3'h7)
						rs_reg <= par_on ? R_PAR : R_STOP;
				end
			end
			R_PAR: begin
				if (rfull)
					rs_reg <= R_STOP;
			end
			R_STOP: begin
				if (rfull) begin
					rs_reg <= R_IDLE;
					if (i_rxd & ~(sw & ((rsh_reg == xon_reg) | (rsh_reg == xoff_reg)))) begin
						rpush_reg <= 1'b1;
						rbyte_reg <= rsh_reg;
					end
				end
			end
			default: rs_reg <= R_IDLE;
			endcase
		end
	end

	wire r_par_bad  = (rs_reg == R_PAR) & rfull & (i_rxd != f_par(pmode, rsh_reg));
	wire r_frm_bad  = (rs_reg == R_STOP) & rfull & ~i_rxd;
	wire r_xoff     = (rs_reg == R_STOP) & rfull & i_rxd & sw & (rsh_reg == xoff_reg); // RL17
	wire r_xon      = (rs_reg == R_STOP) & rfull & i_rxd & sw & (rsh_reg == xon_reg);
	wire r_ovf      = rpush_reg & ~rx_ready;
	wire stat_wr    = i_wr & (i_addr == `SPM_A_STAT);

	//==================================================
	// registers
	always @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg  <= `SPM_CTRL_RST; // RL18
			wait_reg  <= `SPM_WAIT_RST;
			xon_reg   <= `SPM_XON_RST;
			xoff_reg  <= `SPM_XOFF_RST;
			xhold_reg <= 1'b0;
			abort_reg <= 1'b0;
			ovf_reg   <= 1'b0;
			perr_reg  <= 1'b0;
			ferr_reg  <= 1'b0;
			o_rdata   <= 32'h0;
		end else begin
			if (i_wr) begin
				case (i_addr)
				`SPM_A_CTRL: ctrl_reg <= i_wdata[9:0]; // RL18
				`SPM_A_WAIT: wait_reg <= i_wdata[15:0]; // RL4
				`SPM_A_XCHR: begin
					xon_reg  <= i_wdata[7:0]; // RL16
					xoff_reg <= i_wdata[15:8];
				end
				default: ;
				endcase
			end
			if (r_xoff)
				xhold_reg <= 1'b1; // RL14
			else if (r_xon | ~sw)
				xhold_reg <= 1'b0;
			abort_reg <= t_abort | (abort_reg & ~(stat_wr & i_wdata[`SPM_S_ABORT])); // RL5
			ovf_reg   <= r_ovf | (ovf_reg & ~(stat_wr & i_wdata[`SPM_S_OVF])); // RL19
			perr_reg  <= r_par_bad | (perr_reg & ~(stat_wr & i_wdata[`SPM_S_PERR]));
			ferr_reg  <= r_frm_bad | (ferr_reg & ~(stat_wr & i_wdata[`SPM_S_FERR]));
			o_rdata <= 32'h0;
			if (i_rd) begin
				case (i_addr)
				`SPM_A_CTRL: o_rdata <= {22'h0, ctrl_reg};
				`SPM_A_WAIT: o_rdata <= {16'h0, wait_reg};
				`SPM_A_XCHR: o_rdata <= {16'h0, xoff_reg, xon_reg};
				`SPM_A_RXD:  o_rdata <= {24'h0, rx_valid ? rx_data : 8'h0};
				`SPM_A_STAT: o_rdata <= {23'h0, ferr_reg, perr_reg, ovf_reg, abort_reg, xhold_reg,
					(ts_reg != T_IDLE), rx_valid, ~tx_ready, ~tx_valid};
				default:     o_rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule // spm_top
